// ==== tb/pllref_properties.sv ====
`timescale 1ns/1ps
module pllref_properties #(
  parameter logic [2:0] NEW_OSC_CONFIG    = 3'h1,
  parameter logic       PLL_SOURCE_SEL    = 1'b1,
  parameter logic [3:0] PLL_PRESCALE_MODE = 4'h0
) (
  // clock, reset, apb
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pin
  input wire logic        REF_PIN_OE_N
);
  // expected pll source: the osc select wins over the source bit
  localparam logic PLL_PRI = (NEW_OSC_CONFIG == 3'h3) ? 1'b1 :
                             (NEW_OSC_CONFIG == 3'h1) ? 1'b0 : PLL_SOURCE_SEL;
  logic acc;
  logic rd;
  logic mapped;
  logic [3:0] pre_div;

  // access taken this edge, and whether it hits a register
  assign acc    = PSEL && PENABLE && !PREADY;
  assign rd     = acc && !PWRITE;
  assign mapped = PADDR <= pllref_pkg::OFS_CLK_STAT && PADDR[1:0] == 2'h0;

  // prescale divisor of each mode; codes above 7 unused
  always_comb
  begin
    case (PLL_PRESCALE_MODE)
      4'h6: pre_div = 4'h8;
      4'h7: pre_div = 4'hC;
      default: pre_div = PLL_PRESCALE_MODE + 4'h1;
    endcase
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_answer; acc |-> ##1 PREADY; endproperty
  a_answer: assert property (p_answer) else $error("no ready after access");
  property p_pulse; $rose(PREADY) |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
  property p_hold; $fell(PREADY) |-> $stable(PRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data did not hold");
  property p_unmapped; acc && !mapped |=> PREADY && PSLVERR; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  property p_div_top; rd && PADDR == pllref_pkg::OFS_CTRL_HIGH |=> PRDATA[31:15] == 17'h0;
  endproperty
  a_div_top: assert property (p_div_top) else $error("divider top bit set");
  property p_trim; rd && PADDR == pllref_pkg::OFS_TRIM |=> PRDATA[6:0] == 7'h0;
  endproperty
  a_trim: assert property (p_trim) else $error("trim low bits set");
  property p_osc; rd && PADDR == pllref_pkg::OFS_CLK_STAT |=> PRDATA[2:0] == NEW_OSC_CONFIG;
  endproperty
  a_osc: assert property (p_osc) else $error("osc select not from config");
  property p_src; rd && PADDR == pllref_pkg::OFS_CLK_STAT |=> PRDATA[4] == PLL_PRI;
  endproperty
  a_src: assert property (p_src) else $error("wrong pll source");
  property p_pre; rd && PADDR == pllref_pkg::OFS_CLK_STAT |=> PRDATA[11:8] == pre_div;
  endproperty
  a_pre: assert property (p_pre) else $error("wrong prescale divisor");

  // main scenarios
  c_write: cover property (acc && PWRITE);
  c_err: cover property (PSLVERR);
  c_drive: cover property (!REF_PIN_OE_N);
endmodule

bind pllref_top pllref_properties #(
  .NEW_OSC_CONFIG(NEW_OSC_CONFIG),
  .PLL_SOURCE_SEL(PLL_SOURCE_SEL),
  .PLL_PRESCALE_MODE(PLL_PRESCALE_MODE)
) u_props (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .REF_PIN_OE_N(REF_PIN_OE_N));

// ==== tb/pllref_src_model.sv ====
`timescale 1ns/1ps
module pllref_src_model (
  // system clock
  input wire logic clk,
  // oscillator levels
  output logic     src_pri,
  output logic     src_frc,
  output logic     src_pll,
  output logic     src_sys
);
  logic [3:0] cnt_ff = 4'h0;

  // oscillators run free, even in reset; sys period is 8 clocks
  always_ff @(posedge clk)
    cnt_ff <= cnt_ff + 4'h1;
  assign src_pri = cnt_ff[3];
  assign src_frc = cnt_ff[1];
  assign src_pll = cnt_ff[0];
  assign src_sys = cnt_ff[2];
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clock      = 1'b0;
  logic        rst_n      = 1'b0;
  logic        sleep      = 1'b0;
  logic        slp_ok     = 1'b0;
  logic        err;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        oe_n;
  logic        s_pri;
  logic        s_frc;
  logic        s_pll;
  logic        s_sys;
  logic [31:0] rdata;
  logic [31:0] prdata;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          edges      = 0;
  pllref_pkg::pllref_apb_t apb = '0;

  // defaults: fast rc pll, prescale 1 for a 4 MHz input
  pllref_top dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(apb.psel), .PENABLE(apb.penable),
    .PWRITE(apb.pwrite), .PADDR(apb.paddr), .PWDATA(apb.pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_PRIMARY(s_pri), .SRC_FAST_RC(s_frc),
    .SRC_PLL(s_pll), .SRC_SYSCLK(s_sys), .SLEEP(sleep), .SRC_RUNS_IN_SLEEP(slp_ok),
    .REF_PIN_OUT(pin), .REF_PIN_OE_N(oe_n));
  pllref_src_model partner (.clk(clock), .src_pri(s_pri), .src_frc(s_frc),
    .src_pll(s_pll), .src_sys(s_sys));

  // 50 ns clock; output edges counted for the sleep cases
  always #25 clock = ~clock;
  always @(posedge pin) edges++;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apb.penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    apb   <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // poll a control bit, bounded so a stuck bit still ends
  task automatic poll(input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      xfer(1'b0, pllref_pkg::OFS_CTRL_LOW, 32'h0);
      i++;
    end
    while (i < 200 && rdata[b] !== v);
    chk(32'(rdata[b]), 32'(v));
  endtask

  task automatic period(input int exp);
    time t0;
    @(posedge pin);
    t0 = $time;
    @(posedge pin);
    chk(32'(($time - t0) / 50), 32'(exp));
  endtask

  task automatic t_regs;
    for (int i = 0; i < 16; i += 4)
      rd_chk(8'(i), 32'h0);
    xfer(1'b1, pllref_pkg::OFS_CTRL_HIGH, 32'hFFFFFFFF);
    rd_chk(pllref_pkg::OFS_CTRL_HIGH, 32'h7FFF);
    xfer(1'b1, pllref_pkg::OFS_TRIM, 32'hFFFFFFFF);
    rd_chk(pllref_pkg::OFS_TRIM, 32'hFF80);
    xfer(1'b1, pllref_pkg::OFS_TRIM, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
  endtask

  // clock status reports multiplier and postscaler for five configurations, the last one usb
  task automatic t_stat;
    logic [4:0] cfg [5] = '{5'h00, 5'h05, 5'h0A, 5'h03, 5'h11};
    logic [4:0] mul [5] = '{5'h04, 5'h06, 5'h08, 5'h04, 5'h18};
    logic [3:0] pst [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h2};
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, pllref_pkg::OFS_CLK_CFG, 32'(cfg[i]));
      xfer(1'b1, pllref_pkg::OFS_CLK_STAT, 32'hFFFFFFFF);
      xfer(1'b0, pllref_pkg::OFS_CLK_STAT, 32'h0);
      chk(32'(rdata[16:12]), 32'(mul[i]));
      chk(32'(rdata[20:17]), 32'(pst[i]));
      chk(32'({rdata[11:8], rdata[4], rdata[2:0]}), 32'h11);
    end
  endtask

  task automatic t_ref;
    xfer(1'b1, pllref_pkg::OFS_CTRL_HIGH, 32'h2);
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h9000);
    rd_chk(pllref_pkg::OFS_CTRL_LOW, 32'h9100);
    chk(32'(oe_n), 32'h0);
    period(32);
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h8000);
    rd_chk(pllref_pkg::OFS_CTRL_LOW, 32'h8100);
    chk(32'(oe_n), 32'h1);
    xfer(1'b1, pllref_pkg::OFS_CTRL_HIGH, 32'h3);
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h9200);
    poll(9, 1'b0);
    period(48);
    xfer(1'b1, pllref_pkg::OFS_CTRL_HIGH, 32'h0);
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h9200);
    poll(9, 1'b0);
    period(8);
  endtask

  // sleep gates the output unless both sleep conditions hold
  task automatic t_sleep;
    int e;
    sleep <= 1'b1;
    repeat (10) @(posedge clock);
    e = edges;
    repeat (100) @(posedge clock);
    chk(32'(edges - e), 32'h0);
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h9800);
    slp_ok <= 1'b1;
    repeat (10) @(posedge clock);
    e = edges;
    repeat (100) @(posedge clock);
    chk(32'(edges > e), 32'h1);
    sleep <= 1'b0;
    xfer(1'b1, pllref_pkg::OFS_CTRL_LOW, 32'h1000);
    poll(8, 1'b0);
    chk(32'({pin, oe_n}), 32'h1);
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_stat;
    t_ref;
    t_sleep;
    end_sim;
  end

  // watchdog well past the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_sim;
  end
endmodule

// ==== verilog/pllref_pkg.sv ====
package pllref_pkg;

  // register byte addresses on the APB bus
  localparam logic [7:0] OFS_CTRL_LOW  = 8'h00;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
  localparam logic [7:0] OFS_TRIM      = 8'h08;
  localparam logic [7:0] OFS_CLK_CFG   = 8'h0C;
  localparam logic [7:0] OFS_CLK_STAT  = 8'h10;

  // control low field positions
  localparam int BIT_ENABLE   = 15;
  localparam int BIT_SLEEPRUN = 11;
  localparam int BIT_SWITCH   = 9;
  localparam int BIT_ACTIVE   = 8;
  localparam int BIT_PINDRIVE = 12;
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 4;

  // trim register field position and width; divider field width
  localparam int TRIM_LSB = 7;
  localparam int TRIM_W   = 9;
  localparam int DIV_W    = 15;

  // clock configuration field positions
  localparam int POST_LSB = 0;
  localparam int MULT_LSB = 2;
  localparam int USB_BIT  = 4;

  // oscillator select encodings
  localparam logic [2:0] OSC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;

  // reference source encodings
  localparam logic [3:0] REFSRC_SYS = 4'h0;
  localparam logic [3:0] REFSRC_PRI = 4'h1;
  localparam logic [3:0] REFSRC_FRC = 4'h2;
  localparam logic [3:0] REFSRC_PLL = 4'h3;

  // reset values
  localparam logic [15:0] RST_CTRL_LOW  = 16'h0000;
  localparam logic [15:0] RST_CTRL_HIGH = 16'h0000;
  localparam logic [15:0] RST_TRIM      = 16'h0000;
  localparam logic [4:0]  RST_CLK_CFG   = 5'h00;

  // pll non-usb multiplier codes
  localparam logic [1:0] MULT_X4 = 2'h0;
  localparam logic [1:0] MULT_X6 = 2'h1;
  localparam logic [1:0] MULT_X8 = 2'h2;

  // reference divider states
  typedef enum logic [2:0] {
    RS_IDLE  = 3'h1,
    RS_RUN   = 3'h2,
    RS_DRAIN = 3'h4
  } pllref_state_t;

  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pllref_apb_t;

  // whole module state
  typedef struct packed {
    pllref_state_t st;
    logic [15:0]   ctrl_low;
    logic [14:0]   div;
    logic [8:0]    trim;
    logic [14:0]   act_div;
    logic [8:0]    act_trim;
    logic [4:0]    clk_cfg;
    logic [2:0]    cur_osc;
    logic [14:0]   cnt;
    logic [9:0]    frac;
    logic          ref_lvl;
    logic          src_q;
    logic          fired;
    logic [1:0]    src_sync;
    logic [1:0]    slp_sync;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          pin_out;
    logic          pin_oe_n;
  } pllref_state_s_t;

endpackage

// ==== verilog/pllref_top.sv ====
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
// Contract
// [RULE_01] pll input from fast rc when osc select is 001, primary when 011
// [RULE_02] osc select loads from new-oscillator configuration bits at reset
// [RULE_03] otherwise pll source follows pll source select bit, 0 fast rc
// [RULE_04] usb mode: pll runs 96 MHz, fixed divide by 2 gives 48 MHz
// [RULE_05] usb mode: system branch divides 96 MHz by 3 then postscaler
// [RULE_06] postscaler 00 none, 01 by 2, 10 by 4, 11 by 8
// [RULE_07] software disables usb before picking system clock below 16 MHz
// [RULE_08] configuration sets prescaler so pll input is exactly 4 MHz
// [RULE_09] prescale mode 0..7 divides by 1,2,3,4,5,6,8,12
// [RULE_10] non-usb mode offers 4x, 6x, 8x multipliers without prescaler
// [RULE_11] non-usb mode keeps postscaler available
// [RULE_12] configuration keeps pll input 2..8 MHz and system clock under 32 MHz
// [RULE_13] enable bit 15 of control low puts reference clock on pin
// [RULE_14] output is input over 2*(N+M/512); N zero passes input through
// [RULE_15] divider in high bits 14:0 is half period; bit 15 reads zero
// [RULE_16] 9-bit trim in trim bits 15:7 adds fraction in 1/512 steps
// [RULE_17] switch bit 9 set by software, cleared by hardware when applied
// [RULE_18] source select bits 3:0 pick input; zero follows system clock
// [RULE_19] output runs in sleep only with sleep-run bit and source alive
// [RULE_20] active bit 8 shows running, clears after enable cleared
// [RULE_21] pin drive bit connects or disconnects reference pin
// [RULE_22] new divider and trim apply only at an output period boundary; the code applies them at once in pass-through
// [RULE_23] active stays set until output cycle done and pin back idle
module pllref_top #(
  parameter logic [2:0] NEW_OSC_CONFIG   = 3'h1,
  parameter logic       PLL_SOURCE_SEL   = 1'b1,
  parameter logic [3:0] PLL_PRESCALE_MODE = 4'h0
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // clock sources, levels from the oscillator block, synchronised and edge-detected here
  input  wire logic        SRC_PRIMARY,
  input  wire logic        SRC_FAST_RC,
  input  wire logic        SRC_PLL,
  input  wire logic        SRC_SYSCLK,
  // sleep state and whether the selected source keeps running in sleep
  input  wire logic        SLEEP,
  input  wire logic        SRC_RUNS_IN_SLEEP,
  // reference pin, output enable low while driving
  output logic             REF_PIN_OUT,
  output logic             REF_PIN_OE_N
);

  pllref_pkg::pllref_state_s_t s_ff;
  pllref_pkg::pllref_state_s_t nxt_s;
  pllref_pkg::pllref_apb_t     apb;

  logic        pll_from_primary;
  logic [3:0]  prescale_div;
  logic [4:0]  pll_mult;
  logic [3:0]  post_div;
  logic        src_sel;
  logic        src_edge;
  logic        run_ok;
  logic [9:0]  frac_sum;
  logic [14:0] half_len;
  logic        at_boundary;

  // prescaler division for the usb pll input
  function automatic logic [3:0] prescale_of(input logic [3:0] mode);
    case (mode)
      4'h0:    prescale_of = 4'h1;
      4'h1:    prescale_of = 4'h2;
      4'h2:    prescale_of = 4'h3;
      4'h3:    prescale_of = 4'h4;
      4'h4:    prescale_of = 4'h5;
      4'h5:    prescale_of = 4'h6;
      4'h6:    prescale_of = 4'h8;
      default: prescale_of = 4'hC;
    endcase
  endfunction

  assign apb = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};

  // pll routing and ratios reported as status only; no port carries them out
  always_comb
  begin
    if (s_ff.cur_osc == pllref_pkg::OSC_FAST_RC_PLL)
      pll_from_primary = 1'b0; // RULE_01
    else if (s_ff.cur_osc == pllref_pkg::OSC_PRIMARY_PLL)
      pll_from_primary = 1'b1; // RULE_01
    else
      pll_from_primary = PLL_SOURCE_SEL; // RULE_03
    prescale_div = prescale_of(PLL_PRESCALE_MODE); // RULE_09
    if (s_ff.clk_cfg[pllref_pkg::USB_BIT])
      pll_mult = 5'h18; // RULE_04 4 MHz x24 = 96 MHz, /2 usb, /3 system
    else
      case (s_ff.clk_cfg[pllref_pkg::MULT_LSB +: 2])
        pllref_pkg::MULT_X6: pll_mult = 5'h06; // RULE_10
        pllref_pkg::MULT_X8: pll_mult = 5'h08; // RULE_10
        default:             pll_mult = 5'h04; // RULE_10
      endcase
    // postscaler in both modes; usb limit is software's job
    post_div = 4'h1 << s_ff.clk_cfg[pllref_pkg::POST_LSB +: 2]; // RULE_06 RULE_11 RULE_05
  end

  // source select; zero tracks the system clock through switches
  always_comb
  begin
    case (s_ff.ctrl_low[pllref_pkg::SEL_LSB +: pllref_pkg::SEL_W])
      pllref_pkg::REFSRC_SYS: src_sel = SRC_SYSCLK; // RULE_18
      pllref_pkg::REFSRC_PRI: src_sel = SRC_PRIMARY;
      pllref_pkg::REFSRC_FRC: src_sel = SRC_FAST_RC;
      pllref_pkg::REFSRC_PLL: src_sel = SRC_PLL;
      default:                src_sel = 1'b0;
    endcase
  end

  // rising edge of the synchronised source; sync stage 0 read only by stage 1
  assign src_edge = s_ff.src_sync[1] & ~s_ff.src_q;
  // sleep stops counting unless both sleep-run and source allow it
  assign run_ok = ~s_ff.slp_sync[1]
                | (s_ff.ctrl_low[pllref_pkg::BIT_SLEEPRUN] & SRC_RUNS_IN_SLEEP); // RULE_19
  // fractional trim accumulates; carry stretches one half period by a source clock
  assign frac_sum = {1'b0, s_ff.frac[8:0]} + {1'b0, s_ff.act_trim}; // RULE_16 RULE_14
  assign half_len = frac_sum[9] ? s_ff.act_div : s_ff.act_div - 15'h0001;
  // a full output period ends when the output falls back low
  assign at_boundary = src_edge & run_ok & s_ff.ref_lvl & (s_ff.cnt == 15'h0000);

  // next-state logic
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.src_sync = {s_ff.src_sync[0], src_sel};
    nxt_s.slp_sync = {s_ff.slp_sync[0], SLEEP};
    nxt_s.src_q = s_ff.src_sync[1];
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;

    // reference divider state machine
    case (s_ff.st)
      pllref_pkg::RS_IDLE:
      begin
        nxt_s.ref_lvl = 1'b0;
        nxt_s.cnt = 15'h0000;
        if (s_ff.ctrl_low[pllref_pkg::BIT_ENABLE])
        begin
          nxt_s.st = pllref_pkg::RS_RUN;
          nxt_s.ctrl_low[pllref_pkg::BIT_ACTIVE] = 1'b1; // RULE_20
          nxt_s.act_div = s_ff.div;
          nxt_s.act_trim = s_ff.trim;
          nxt_s.frac = 10'h000;
        end
      end
      pllref_pkg::RS_RUN, pllref_pkg::RS_DRAIN:
      begin
        if (s_ff.act_div == 15'h0000)
        begin
          // pass-through freezes in sleep too, else sleep gating leaks
          if (run_ok)
            nxt_s.ref_lvl = s_ff.src_sync[1]; // RULE_14 RULE_19
          nxt_s.fired = s_ff.src_sync[1] & ~s_ff.src_q;
        end
        else if (src_edge & run_ok)
        begin
          if (s_ff.cnt == 15'h0000)
          begin
            nxt_s.ref_lvl = ~s_ff.ref_lvl; // RULE_14
            nxt_s.cnt = half_len; // RULE_15
            nxt_s.frac = {1'b0, frac_sum[8:0]};
          end
          else
            nxt_s.cnt = s_ff.cnt - 15'h0001;
        end
        // apply a pending switch where a period ends, or at once in pass-through
        if (s_ff.ctrl_low[pllref_pkg::BIT_SWITCH]
            && (at_boundary || s_ff.act_div == 15'h0000))
        begin
          nxt_s.act_div = s_ff.div; // RULE_22
          nxt_s.act_trim = s_ff.trim; // RULE_22
          nxt_s.ctrl_low[pllref_pkg::BIT_SWITCH] = 1'b0; // RULE_17
          // next half period already uses the new divider, no mixed period
          if (at_boundary)
          begin
            nxt_s.cnt = s_ff.div - 15'h0001; // RULE_22
            nxt_s.frac = 10'h000;
          end
        end
        if (!s_ff.ctrl_low[pllref_pkg::BIT_ENABLE])
          nxt_s.st = pllref_pkg::RS_DRAIN;
        // finish the cycle before dropping active
        if (s_ff.st == pllref_pkg::RS_DRAIN && !s_ff.ref_lvl
            && (s_ff.cnt == 15'h0000 || s_ff.act_div == 15'h0000))
        begin
          nxt_s.st = pllref_pkg::RS_IDLE;
          nxt_s.ref_lvl = 1'b0;
          nxt_s.ctrl_low[pllref_pkg::BIT_ACTIVE] = 1'b0; // RULE_23 RULE_20
        end
      end
      default:
        nxt_s.st = pllref_pkg::RS_IDLE;
    endcase

    // pin: level needs enable only, drive needs enable and pin-drive
    nxt_s.pin_out = s_ff.ref_lvl & s_ff.ctrl_low[pllref_pkg::BIT_ENABLE]; // RULE_13
    nxt_s.pin_oe_n = ~(s_ff.ctrl_low[pllref_pkg::BIT_ENABLE]
                     & s_ff.ctrl_low[pllref_pkg::BIT_PINDRIVE]); // RULE_21

    // apb access phase, one wait state, ready registered
    if (apb.psel && apb.penable && !s_ff.pready)
    begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = 32'h0000_0000;
      case (apb.paddr)
        pllref_pkg::OFS_CTRL_LOW:
          if (apb.pwrite)
          begin
            nxt_s.ctrl_low[15:12] = apb.pwdata[15:12];
            nxt_s.ctrl_low[11] = apb.pwdata[11];
            // switch bit: software sets, only hardware clears
            if (apb.pwdata[pllref_pkg::BIT_SWITCH])
              nxt_s.ctrl_low[pllref_pkg::BIT_SWITCH] = 1'b1; // RULE_17
            nxt_s.ctrl_low[3:0] = apb.pwdata[3:0]; // RULE_18
          end
          else
            nxt_s.prdata = {16'h0000, s_ff.ctrl_low};
        pllref_pkg::OFS_CTRL_HIGH:
          if (apb.pwrite)
            nxt_s.div = apb.pwdata[14:0]; // RULE_15
          else
            nxt_s.prdata = {17'h00000, s_ff.div}; // RULE_15 bit 15 zero
        pllref_pkg::OFS_TRIM:
          if (apb.pwrite)
            nxt_s.trim = apb.pwdata[pllref_pkg::TRIM_LSB +: pllref_pkg::TRIM_W]; // RULE_16
          else
            nxt_s.prdata = {16'h0000, s_ff.trim, 7'h00};
        pllref_pkg::OFS_CLK_CFG:
          if (apb.pwrite)
            nxt_s.clk_cfg = apb.pwdata[4:0];
          else
            nxt_s.prdata = {27'h0000000, s_ff.clk_cfg};
        pllref_pkg::OFS_CLK_STAT:
          if (!apb.pwrite)
            nxt_s.prdata = {11'h000, post_div, pll_mult, prescale_div,
                            3'h0, pll_from_primary, 1'b0, s_ff.cur_osc};
        default:
          nxt_s.pslverr = 1'b1;
      endcase
    end
  end

  // single state register; configuration captured in the reset branch
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      s_ff <= '0;
      s_ff.st <= pllref_pkg::RS_IDLE;
      s_ff.ctrl_low <= pllref_pkg::RST_CTRL_LOW;
      s_ff.clk_cfg <= pllref_pkg::RST_CLK_CFG;
      s_ff.cur_osc <= NEW_OSC_CONFIG; // RULE_02
      s_ff.pin_oe_n <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign PRDATA = s_ff.prdata;
  assign PREADY = s_ff.pready;
  assign PSLVERR = s_ff.pslverr;
  assign REF_PIN_OUT = s_ff.pin_out;
  assign REF_PIN_OE_N = s_ff.pin_oe_n;

endmodule
